// >>> hw/ddcnm_regs.vh
// Register offsets, field positions, reset values and latency counts
`ifndef DDCNM_REGS_VH
`define DDCNM_REGS_VH
`define DDCNM_A_SRC_OFS      16'h500F
`define DDCNM_A_IDX_OFS      16'h5010
`define DDCNM_A_PIN_OFS      16'h5438
`define DDCNM_B_SRC_OFS      16'h580F
`define DDCNM_B_IDX_OFS      16'h5810
`define DDCNM_B_PIN_OFS      16'h5C38
`define DDCNM_A_FW_BASE      16'h5020
`define DDCNM_B_FW_BASE      16'h5820
`define DDCNM_MODE_OFS       16'h5030
`define DDCNM_STAT_OFS       16'h5031
`define DDCNM_SRC_PIN_BIT    0
`define DDCNM_MODE_MUX_BIT   0
`define DDCNM_MODE_DEC_LSB   4
`define DDCNM_SRC_RST        8'h00
`define DDCNM_IDX_RST        8'h00
`define DDCNM_PIN_RST        8'h00
`define DDCNM_MODE_RST       8'h00
`define DDCNM_FW_RST         16'h0000
`define DDCNM_DEC_BYPASS     4'h0
`define DDCNM_DEC_4          4'h1
`define DDCNM_DEC_6          4'h2
`define DDCNM_DEC_8          4'h3
`define DDCNM_DEC_9          4'h4
`define DDCNM_DEC_10         4'h5
`define DDCNM_DEC_12         4'h6
`define DDCNM_DEC_16         4'h7
`define DDCNM_DEC_18         4'h8
`define DDCNM_DEC_20         4'h9
`define DDCNM_DEC_24         4'hA
`define DDCNM_DEC_32         4'hB
`define DDCNM_LATH_BYPASS    12'd848
`define DDCNM_LATH_4         12'd1032
`define DDCNM_LATH_6         12'd1492
`define DDCNM_LATH_8         12'd1242
`define DDCNM_LATH_9         12'd1527
`define DDCNM_LATH_10        12'd1622
`define DDCNM_LATH_12        12'd1794
`define DDCNM_LATH_16        12'd2090
`define DDCNM_LATH_18        12'd2328
`define DDCNM_LATH_20        12'd2512
`define DDCNM_LATH_24        12'd2886
`define DDCNM_LATH_32        12'd3546
`define DDCNM_PIPE_OVH       12'd3
`endif

// >>> hw/ddcnm_ring_mem.v
// Simple dual-port sample memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module ddcnm_ring_mem #(
  parameter W  = 96,
  parameter AW = 11
) (
  input  wire          clk_i,
  input  wire          wr_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [W-1:0]  wdata_i,
  input  wire          rd_i,
  input  wire [AW-1:0] raddr_i,
  output reg  [W-1:0]  rdata_o
);
  reg [W-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_i) begin
    if (wr_i) begin
      mem[waddr_i] <= wdata_i;
    end
    if (rd_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // ddcnm_ring_mem
`default_nettype wire

// >>> hw/ddcnm_skid2.v
// Two-entry output buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ddcnm_skid2 #(
  parameter W = 96
) (
  input  wire         clk_i,
  input  wire         nrst_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o,
  output wire [1:0]   count_o
);
  reg [W-1:0] ent0;
  reg [W-1:0] ent1;
  reg [1:0]   count;
  wire        push;
  wire        pop;

  assign in_ready_o  = (count != 2'd2);
  assign out_valid_o = (count != 2'd0);
  assign out_data_o  = ent0;
  assign count_o     = count;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= 2'd0;
      ent0  <= {W{1'b0}};
      ent1  <= {W{1'b0}};
    end else begin
      if (pop) begin
        ent0 <= (count == 2'd2) ? ent1 : in_data_i;
        if (count == 2'd2 && push) begin
          ent1 <= in_data_i;
        end
      end else if (push) begin
        if (count == 2'd0) begin
          ent0 <= in_data_i;
        end else begin
          ent1 <= in_data_i;
        end
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // ddcnm_skid2
`default_nettype wire

// >>> hw/ddcnm_top.v
// Oscillators, mixers, hop selection, channel mux and latency pipeline
`include "ddcnm_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module ddcnm_top #(
  parameter SW = 12,
  parameter AW = 11
) (
  input  wire          CLK_I,
  input  wire          NRST_I,
  input  wire [15:0]   REG_ADDR_I,
  input  wire [7:0]    REG_WDATA_I,
  input  wire          REG_WR_I,
  input  wire          REG_RD_I,
  output reg  [7:0]    REG_RDATA_O,
  input  wire [SW-1:0] ADC_A_I,
  input  wire [SW-1:0] ADC_B_I,
  input  wire          SAMPLE_VALID_I,
  input  wire [3:0]    GPIO_I,
  input  wire          SYSREF_I,
  output wire          OUT_VALID_O,
  input  wire          OUT_READY_I,
  output wire [8*SW-1:0] OUT_DATA_O,
  output wire          DDC1_ACTIVE_O,
  output reg           OVERRUN_O
);
  localparam MW = 8 * SW;

  // Quarter-wave sine, 6-bit phase, signed 9-bit amplitude
  function [8:0] sin9;
    input [5:0] ph;
    reg   [3:0] q;
    reg   [7:0] m;
    begin
      q = ph[4] ? (4'hF - ph[3:0]) : ph[3:0];
      case (q)
        4'h0: m = 8'h0C;
        4'h1: m = 8'h25;
        4'h2: m = 8'h3D;
        4'h3: m = 8'h55;
        4'h4: m = 8'h6B;
        4'h5: m = 8'h80;
        4'h6: m = 8'h93;
        4'h7: m = 8'hA5;
        4'h8: m = 8'hB5;
        4'h9: m = 8'hC3;
        4'hA: m = 8'hCF;
        4'hB: m = 8'hD9;
        4'hC: m = 8'hE1;
        4'hD: m = 8'hE7;
        4'hE: m = 8'hEB;
        default: m = 8'hEE;
      endcase
      sin9 = ph[5] ? (9'h000 - {1'b0, m}) : {1'b0, m};
    end
  endfunction

  // Pin assignment decode to GPIO index (GPIO1 is bit 0)
  function [1:0] pin_idx;
    input [1:0] code;
    begin
      case (code)
        2'b00:   pin_idx = 2'd3;
        2'b01:   pin_idx = 2'd0;
        2'b10:   pin_idx = 2'd2;
        default: pin_idx = 2'd1;
      endcase
    end
  endfunction

  // Latency in half cycles for the decimation code
  function [11:0] lat_half;
    input [3:0] dec;
    begin
      case (dec)
        `DDCNM_DEC_4:  lat_half = `DDCNM_LATH_4;
        `DDCNM_DEC_6:  lat_half = `DDCNM_LATH_6;
        `DDCNM_DEC_8:  lat_half = `DDCNM_LATH_8;
        `DDCNM_DEC_9:  lat_half = `DDCNM_LATH_9;
        `DDCNM_DEC_10: lat_half = `DDCNM_LATH_10;
        `DDCNM_DEC_12: lat_half = `DDCNM_LATH_12;
        `DDCNM_DEC_16: lat_half = `DDCNM_LATH_16;
        `DDCNM_DEC_18: lat_half = `DDCNM_LATH_18;
        `DDCNM_DEC_20: lat_half = `DDCNM_LATH_20;
        `DDCNM_DEC_24: lat_half = `DDCNM_LATH_24;
        `DDCNM_DEC_32: lat_half = `DDCNM_LATH_32;
        default:       lat_half = `DDCNM_LATH_BYPASS;
      endcase
    end
  endfunction

  // Registers
  reg  [7:0]  src_reg [0:1];
  reg  [7:0]  idx_reg [0:1];
  reg  [7:0]  pin_reg [0:1];
  reg  [7:0]  mode_reg;
  reg  [15:0] fw [0:7];
  reg  [1:0]  cur_sel [0:1];
  reg  [15:0] acc [0:7];
  reg         sysref_d;
  wire        align;
  wire [3:0]  dec;
  wire        bypass;
  wire        wide;
  wire        mux_on;
  wire        mode_wr;

  assign dec     = mode_reg[`DDCNM_MODE_DEC_LSB+3:`DDCNM_MODE_DEC_LSB];
  assign bypass  = (dec == `DDCNM_DEC_BYPASS);
  assign wide    = (dec == `DDCNM_DEC_4) || (dec == `DDCNM_DEC_6);
  assign mux_on  = mode_reg[`DDCNM_MODE_MUX_BIT];
  assign mode_wr = REG_WR_I && (REG_ADDR_I == `DDCNM_MODE_OFS);
  assign align   = SYSREF_I && !sysref_d;
  assign DDC1_ACTIVE_O = !wide && !bypass;

  always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mode_reg <= `DDCNM_MODE_RST;
      sysref_d <= 1'b0;
    end else begin
      sysref_d <= SYSREF_I;
      if (mode_wr) begin
        mode_reg <= REG_WDATA_I;
      end
    end
  end

  genvar c;
  genvar k;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      wire [15:0] src_ofs;
      wire [15:0] idx_ofs;
      wire [15:0] pin_ofs;
      wire [1:0]  req;
      assign src_ofs = (c == 0) ? `DDCNM_A_SRC_OFS : `DDCNM_B_SRC_OFS;
      assign idx_ofs = (c == 0) ? `DDCNM_A_IDX_OFS : `DDCNM_B_IDX_OFS;
      assign pin_ofs = (c == 0) ? `DDCNM_A_PIN_OFS : `DDCNM_B_PIN_OFS;
      // Register or pin source for the hop index
      assign req = src_reg[c][`DDCNM_SRC_PIN_BIT] ?
                   {GPIO_I[pin_idx(pin_reg[c][3:2])],
                    GPIO_I[pin_idx(pin_reg[c][1:0])]} :
                   idx_reg[c][1:0];

      always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
          src_reg[c] <= `DDCNM_SRC_RST;
          idx_reg[c] <= `DDCNM_IDX_RST;
          pin_reg[c] <= `DDCNM_PIN_RST;
          cur_sel[c] <= 2'd0;
        end else begin
          if (REG_WR_I && REG_ADDR_I == src_ofs) begin
            src_reg[c] <= REG_WDATA_I;
          end
          if (REG_WR_I && REG_ADDR_I == idx_ofs) begin
            idx_reg[c] <= REG_WDATA_I;
          end
          if (REG_WR_I && REG_ADDR_I == pin_ofs) begin
            pin_reg[c] <= REG_WDATA_I;
          end
          if (req != 2'b11) begin
            cur_sel[c] <= req;
          end
        end
      end

      for (k = 0; k < 4; k = k + 1) begin : g_osc
        localparam [15:0] FW_STEP = 2 * k;
        wire [15:0] base;
        wire [15:0] lo_ofs;
        assign base   = (c == 0) ? `DDCNM_A_FW_BASE : `DDCNM_B_FW_BASE;
        assign lo_ofs = base + FW_STEP;
        always @(posedge CLK_I or negedge NRST_I) begin
          if (!NRST_I) begin
            fw[4*c+k]  <= `DDCNM_FW_RST;
            acc[4*c+k] <= 16'h0000;
          end else begin
            if (REG_WR_I && REG_ADDR_I == lo_ofs) begin
              fw[4*c+k][7:0] <= REG_WDATA_I;
            end
            if (REG_WR_I && REG_ADDR_I == lo_ofs + 16'd1) begin
              fw[4*c+k][15:8] <= REG_WDATA_I;
            end
            if (align) begin
              acc[4*c+k] <= 16'h0000;
            end else if (SAMPLE_VALID_I) begin
              acc[4*c+k] <= acc[4*c+k] + fw[4*c+k];
            end
          end
        end
      end
    end
  endgenerate

  // Mixer inputs
  wire [SW-1:0] samp_a;
  wire [SW-1:0] samp_b;
  reg  [MW-1:0] mix_word;
  reg           mix_valid;
  assign samp_a = ADC_A_I;
  assign samp_b = mux_on ? ADC_A_I : ADC_B_I;

  // Complex mix with e^{-jwn}: I = x*cos, Q = -x*sin
  function [2*SW-1:0] mix;
    input [SW-1:0] x;
    input [15:0]   ph;
    reg   [SW+8:0] pi;
    reg   [SW+8:0] pq;
    reg   [8:0]    sn;
    reg   [8:0]    cs;
    begin
      sn = sin9(ph[15:10]);
      cs = sin9(ph[15:10] + 6'd16);
      pi = $signed(x) * $signed(cs);
      pq = $signed(x) * $signed(sn);
      pq = {(SW+9){1'b0}} - pq;
      mix = {pi[SW+7:8], pq[SW+7:8]};
    end
  endfunction

  wire [15:0] ph0_a;
  wire [15:0] ph0_b;
  assign ph0_a = acc[{1'b0, cur_sel[0]}];
  assign ph0_b = acc[{1'b1, cur_sel[1]}];

  always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mix_word  <= {MW{1'b0}};
      mix_valid <= 1'b0;
    end else begin
      mix_valid <= SAMPLE_VALID_I;
      if (bypass) begin
        mix_word <= {samp_a, {SW{1'b0}}, {(2*SW){1'b0}},
                     samp_b, {SW{1'b0}}, {(2*SW){1'b0}}};
      end else begin
        mix_word <= {mix(samp_a, ph0_a),
                     wide ? {(2*SW){1'b0}} : mix(samp_a, acc[3]),
                     mix(samp_b, ph0_b),
                     wide ? {(2*SW){1'b0}} : mix(samp_b, acc[7])};
      end
    end
  end

  // Latency ring
  reg  [AW-1:0] wr_ptr;
  reg  [AW-1:0] rd_ptr;
  reg           rd_pend;
  wire [AW-1:0] fill;
  wire [11:0]   lat_cyc;
  wire [11:0]   lat_gap;
  wire          full;
  wire          do_wr;
  wire          do_rd;
  wire          skid_ready;
  wire [1:0]    skid_cnt;
  wire [MW:0]   rd_data;

  // Written with a valid bit every cycle unless full or on a mode write, so the delay is fixed while the output keeps up
  assign fill    = wr_ptr - rd_ptr;
  assign lat_cyc = (lat_half(dec) + 12'd1) >> 1;
  assign lat_gap = lat_cyc - `DDCNM_PIPE_OVH;
  assign full    = (fill == {AW{1'b1}});
  assign do_wr   = !full && !mode_wr;
  assign do_rd   = ({{(12-AW){1'b0}}, fill} >= lat_gap) && !mode_wr &&
                   (({1'b0, skid_cnt} + {2'b00, rd_pend} < 3'd2) ||
                    (OUT_VALID_O && OUT_READY_I));

  always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      rd_pend   <= 1'b0;
      OVERRUN_O <= 1'b0;
    end else begin
      rd_pend <= do_rd;
      if (mode_wr) begin
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
      end else begin
        if (do_wr) begin
          wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
        end
        if (do_rd) begin
          rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
        end
      end
      if (mix_valid && full) begin
        OVERRUN_O <= 1'b1;
      end else if (mode_wr) begin
        OVERRUN_O <= 1'b0;
      end
    end
  end

  ddcnm_ring_mem #(
    .W  (MW + 1),
    .AW (AW)
  ) u_mem (
    .clk_i   (CLK_I),
    .wr_i    (do_wr),
    .waddr_i (wr_ptr),
    .wdata_i ({mix_valid, mix_word}),
    .rd_i    (do_rd),
    .raddr_i (rd_ptr),
    .rdata_o (rd_data)
  );

  ddcnm_skid2 #(
    .W (MW)
  ) u_skid (
    .clk_i       (CLK_I),
    .nrst_i      (NRST_I),
    .in_valid_i  (rd_pend && rd_data[MW]),
    .in_ready_o  (skid_ready),
    .in_data_i   (rd_data[MW-1:0]),
    .out_valid_o (OUT_VALID_O),
    .out_ready_i (OUT_READY_I),
    .out_data_o  (OUT_DATA_O),
    .count_o     (skid_cnt)
  );

  // Register read-back
  reg [7:0] next_rdata;
  integer   j;
  always @* begin
    next_rdata = 8'h00;
    case (REG_ADDR_I)
      `DDCNM_A_SRC_OFS: next_rdata = src_reg[0];
      `DDCNM_A_IDX_OFS: next_rdata = idx_reg[0];
      `DDCNM_A_PIN_OFS: next_rdata = pin_reg[0];
      `DDCNM_B_SRC_OFS: next_rdata = src_reg[1];
      `DDCNM_B_IDX_OFS: next_rdata = idx_reg[1];
      `DDCNM_B_PIN_OFS: next_rdata = pin_reg[1];
      `DDCNM_MODE_OFS:  next_rdata = mode_reg;
      `DDCNM_STAT_OFS:  next_rdata = {OVERRUN_O, skid_ready, DDC1_ACTIVE_O,
                                      1'b0, cur_sel[1], cur_sel[0]};
      default: begin
        for (j = 0; j < 8; j = j + 1) begin
          if (REG_ADDR_I == ((j < 4 ? `DDCNM_A_FW_BASE : `DDCNM_B_FW_BASE)
                             + 16'd2 * (j % 4))) begin
            next_rdata = fw[j][7:0];
          end
          if (REG_ADDR_I == ((j < 4 ? `DDCNM_A_FW_BASE : `DDCNM_B_FW_BASE)
                             + 16'd2 * (j % 4) + 16'd1)) begin
            next_rdata = fw[j][15:8];
          end
        end
      end
    endcase
  end

  always @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= next_rdata;
    end
  end
endmodule // ddcnm_top
`default_nettype wire

// >>> test/ddc_nco_mixer_and_switching_bench.sv
// Bench: registers, hop selection, latency table, mux mode and stall
`timescale 1ns/1ps
`default_nettype none
`include "ddcnm_regs.vh"
module ddc_nco_mixer_and_switching_bench;
  logic        CLK_I = 1'b0;
  logic        NRST_I = 1'b0;
  logic [15:0] REG_ADDR_I = 16'h0000;
  logic [7:0]  REG_WDATA_I = 8'h00;
  logic        REG_WR_I = 1'b0;
  logic        REG_RD_I = 1'b0;
  logic [11:0] ADC_A_I = 12'h000;
  logic [11:0] ADC_B_I = 12'h000;
  logic        SAMPLE_VALID_I = 1'b0;
  logic [3:0]  GPIO_I = 4'h0;
  logic        SYSREF_I = 1'b0;
  logic        stall = 1'b0;
  logic        slow = 1'b0;
  logic        mux = 1'b0;
  logic        track = 1'b1;
  logic        lat_pending = 1'b0;
  wire  [7:0]  REG_RDATA_O;
  wire         OUT_VALID_O;
  wire         OUT_READY_I;
  wire         DDC1_ACTIVE_O;
  wire         OVERRUN_O;
  wire  [95:0] OUT_DATA_O;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          exp_lat = 0;
  logic [23:0] qs[$];
  int          qt[$];
  int          pin_of[4] = '{3, 0, 2, 1};
  int          lats[12] = '{424, 516, 746, 621, 764, 811, 897, 1045, 1164,
                            1256, 1443, 1773};

  ddcnm_top DUT (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .ADC_A_I(ADC_A_I), .ADC_B_I(ADC_B_I),
    .SAMPLE_VALID_I(SAMPLE_VALID_I), .GPIO_I(GPIO_I), .SYSREF_I(SYSREF_I),
    .OUT_VALID_O(OUT_VALID_O), .OUT_READY_I(OUT_READY_I),
    .OUT_DATA_O(OUT_DATA_O), .DDC1_ACTIVE_O(DDC1_ACTIVE_O),
    .OVERRUN_O(OVERRUN_O)
  );
  ddcnm_link_sink u_sink (.clk_i(CLK_I), .stall_i(stall), .slow_i(slow),
    .ready_o(OUT_READY_I));

  always #5 CLK_I = ~CLK_I;

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(string what, logic [95:0] seen, logic [95:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Register tasks start and end at a falling edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    REG_ADDR_I = a;
    REG_WDATA_I = d;
    REG_WR_I = 1'b1;
    @(negedge CLK_I);
    REG_WR_I = 1'b0;
    @(negedge CLK_I);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    REG_ADDR_I = a;
    REG_RD_I = 1'b1;
    @(negedge CLK_I);
    REG_RD_I = 1'b0;
    @(negedge CLK_I);
    check("register read", REG_RDATA_O & m, e & m);
  endtask

  task automatic feed(input int n);
    repeat (n) begin
      ADC_A_I = 12'($urandom);
      ADC_B_I = 12'($urandom);
      SAMPLE_VALID_I = 1'b1;
      @(negedge CLK_I);
    end
    SAMPLE_VALID_I = 1'b0;
  endtask

  task automatic run(input logic [7:0] m, input int lat, input int n,
                     input logic s);
    int k;
    wr(`DDCNM_MODE_OFS, m);
    mux = m[0];
    exp_lat = lat;
    lat_pending = !s;
    slow = s;
    feed(n);
    slow = 1'b0;
    k = 0;
    while (qs.size() > 0 && k < 5000) begin
      @(negedge CLK_I);
      k++;
    end
    check("words drained", qs.size(), 0);
  endtask

  // Cycle ceiling
  always @(posedge CLK_I) begin
    if (cyc > 60000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // Reference model: one word per sample, raw samples in bypass
  always @(posedge CLK_I) begin
    logic [23:0] s;
    int t;
    cyc <= cyc + 1;
    if (SAMPLE_VALID_I) begin
      qs.push_back({ADC_A_I, ADC_B_I});
      qt.push_back(cyc);
    end
    if (track && OUT_VALID_O === 1'b1 && OUT_READY_I) begin
      if (qs.size() == 0) begin
        check("spare word", 1, 0);
      end else begin
        s = qs.pop_front();
        t = qt.pop_front();
        if (lat_pending) check("latency", cyc - t, exp_lat);
        lat_pending = 1'b0;
        if (exp_lat == 424) check("bypass word", OUT_DATA_O,
          {s[23:12], 36'h0, mux ? s[23:12] : s[11:0], 36'h0});
      end
    end
  end

  initial begin
    int k, ch, sel, lo, hi;
    logic [15:0] off;
    logic [7:0] v;
    void'($urandom(68));
    repeat (20) @(negedge CLK_I);
    NRST_I = 1'b1;
    @(negedge CLK_I);
    SYSREF_I = 1'b1;
    @(negedge CLK_I);
    SYSREF_I = 1'b0;
    rd(`DDCNM_MODE_OFS, `DDCNM_MODE_RST, 8'hFF);
    wr(16'h5011, 8'hA5);
    rd(16'h5011, 8'h00, 8'hFF);
    rd(16'h1234, 8'h00, 8'hFF);
    for (ch = 0; ch < 2; ch++) begin
      off = ch ? 16'h0800 : 16'h0000;
      rd(`DDCNM_A_SRC_OFS + off, `DDCNM_SRC_RST, 8'hFF);
      rd(`DDCNM_A_IDX_OFS + off, `DDCNM_IDX_RST, 8'hFF);
      rd(`DDCNM_A_PIN_OFS + off, `DDCNM_PIN_RST, 8'hFF);
      for (k = 0; k < 9; k++) begin
        v = 8'($urandom);
        off = (ch ? 16'h0800 : 16'h0000) + (k < 8 ? k : 16'h0418);
        wr(`DDCNM_A_FW_BASE + off, v);
        rd(`DDCNM_A_FW_BASE + off, v, 8'hFF);
      end
      off = ch ? 16'h0800 : 16'h0000;
      sel = 0;
      foreach (lats[k]) begin
        if (k < 5) begin
          v = 8'(k == 1 || k == 3 ? 3 : (k / 2 + 1) % 3);
          wr(`DDCNM_A_IDX_OFS + off, v);
          rd(`DDCNM_A_IDX_OFS + off, v, 8'h03);
          if (v != 3) sel = v;
          rd(`DDCNM_STAT_OFS, 8'(sel << 2 * ch), 8'(3 << 2 * ch));
        end
      end
      wr(`DDCNM_A_SRC_OFS + off, 8'h01);
      for (lo = 0; lo < 4; lo++) begin
        hi = (lo + 1) % 4;
        GPIO_I = 4'h0;
        sel = 0;
        wr(`DDCNM_A_PIN_OFS + off, 8'(hi * 4 + lo));
        repeat (4) begin
          GPIO_I = 4'($urandom);
          repeat (10) @(negedge CLK_I);
          v = 8'({GPIO_I[pin_of[hi]], GPIO_I[pin_of[lo]]});
          if (v != 3) sel = v;
          rd(`DDCNM_STAT_OFS, 8'(sel << 2 * ch), 8'(3 << 2 * ch));
        end
      end
      wr(`DDCNM_A_SRC_OFS + off, 8'h00);
    end
    for (k = 0; k < 12; k++) run(8'(k * 16), lats[k], 20, 1'b0);
    run(8'h01, 424, 20, 1'b0);
    run(8'h31, 621, 20, 1'b0);
    run(8'h00, 424, 300, 1'b1);
    track = 1'b0;
    stall = 1'b1;
    feed(2600);
    check("overrun", OVERRUN_O, 1);
    rd(`DDCNM_STAT_OFS, 8'h80, 8'h80);
    stall = 1'b0;
    wr(`DDCNM_MODE_OFS, 8'h00);
    check("overrun cleared", OVERRUN_O, 0);
    report_and_stop();
  end
endmodule // ddc_nco_mixer_and_switching_bench
`default_nettype wire

// >>> test/ddcnm_link_sink.sv
// Far-side link receiver model: prompt, half-rate or stalled acceptance
`timescale 1ns/1ps
`default_nettype none
module ddcnm_link_sink (
  input  wire logic clk_i,
  input  wire logic stall_i,
  input  wire logic slow_i,
  output var  logic ready_o
);
  initial ready_o = 1'b0;
  always @(negedge clk_i) begin
    ready_o <= !stall_i && (!slow_i || !ready_o);
  end
endmodule // ddcnm_link_sink
`default_nettype wire

// >>> test/ddcnm_top_assertions.sv
// Port-level assertions for the down-conversion top module
`timescale 1ns/1ps
`default_nettype none
`include "ddcnm_regs.vh"
module ddcnm_top_checker #(
  parameter SW = 12
) (
  input wire logic            CLK_I,
  input wire logic            NRST_I,
  input wire logic [15:0]     REG_ADDR_I,
  input wire logic [7:0]      REG_WDATA_I,
  input wire logic            REG_WR_I,
  input wire logic            REG_RD_I,
  input wire logic [7:0]      REG_RDATA_O,
  input wire logic            OUT_VALID_O,
  input wire logic            OUT_READY_I,
  input wire logic [8*SW-1:0] OUT_DATA_O,
  input wire logic            DDC1_ACTIVE_O,
  input wire logic            OVERRUN_O
);
  wire       mode_wr = REG_WR_I && REG_ADDR_I == `DDCNM_MODE_OFS;
  wire [3:0] dec     = REG_WDATA_I[7:4];
  wire       idx_wr  = REG_WR_I && REG_ADDR_I == `DDCNM_A_IDX_OFS;
  wire       idx_rd  = REG_RD_I && REG_ADDR_I == `DDCNM_A_IDX_OFS;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  out_word_hold_a: assert property (OUT_VALID_O && !OUT_READY_I |=>
    OUT_VALID_O && $stable(OUT_DATA_O)) else $error("output word lost");
  ddc1_fields_zero_a: assert property (OUT_VALID_O && !DDC1_ACTIVE_O |->
    OUT_DATA_O[6*SW-1:4*SW] == 0 && OUT_DATA_O[2*SW-1:0] == 0)
    else $error("second converter fields not zero");
  unmapped_read_zero_a: assert property (REG_RD_I &&
    REG_ADDR_I[15:12] != 4'h5 |=> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  index_readback_a: assert property (idx_wr ##2 idx_rd |=>
    REG_RDATA_O[1:0] == $past(REG_WDATA_I[1:0], 3))
    else $error("index readback wrong");
  overrun_sticky_a: assert property (OVERRUN_O && !mode_wr |=> OVERRUN_O)
    else $error("overrun flag cleared early");
  overrun_clear_a: assert property (mode_wr |=> !OVERRUN_O)
    else $error("overrun not cleared by mode write");
  wide_one_ddc_a: assert property (mode_wr &&
    (dec == `DDCNM_DEC_4 || dec == `DDCNM_DEC_6) |=> !DDC1_ACTIVE_O)
    else $error("second converter active in wide mode");
  narrow_two_ddc_a: assert property (mode_wr &&
    dec >= `DDCNM_DEC_8 && dec <= `DDCNM_DEC_32 |=> DDC1_ACTIVE_O)
    else $error("second converter missing");

  cover property (OVERRUN_O);
  cover property (OUT_VALID_O && !OUT_READY_I);
  cover property (OUT_VALID_O && DDC1_ACTIVE_O);
endmodule // ddcnm_top_checker

bind ddcnm_top ddcnm_top_checker #(.SW(SW)) u_checker (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .OUT_VALID_O(OUT_VALID_O),
  .OUT_READY_I(OUT_READY_I), .OUT_DATA_O(OUT_DATA_O),
  .DDC1_ACTIVE_O(DDC1_ACTIVE_O), .OVERRUN_O(OVERRUN_O)
);
`default_nettype wire
